// >>> inc/sdms_pkg.sv
// Shared constants and types of the step/direction microstep sequencer.
// Assumes one system clock at 20 MHz and an APB master with 32-bit data.
package sdms_pkg;

  // ---------------------------------------------------------------------------
  // Sequencer geometry and timing
  // ---------------------------------------------------------------------------
  localparam int          POS_W            = 10;
  localparam int          TABLE_LEN        = 1024;
  localparam int          QUARTER_LEN      = 256;
  localparam int          AMP_W            = 8;
  localparam int          CUR_W            = 9;
  localparam int          RES_W            = 4;
  localparam logic [3:0]  RES_FULLSTEP     = 4'h8;
  localparam int          PER_W            = 21;
  localparam int          STANDSTILL_EXP   = 20;
  localparam int          STANDSTILL_CYCLES = 1 << STANDSTILL_EXP;
  localparam int          CLK_HZ           = 20000000;
  localparam int          STEP_MAX_HZ      = 4000000;
  localparam int          STEP_MIN_CYCLES  = CLK_HZ / STEP_MAX_HZ;
  localparam int          SINE_FULL_SCALE  = 255;

  // ---------------------------------------------------------------------------
  // Register map, byte addresses
  // ---------------------------------------------------------------------------
  localparam int          ADDR_W           = 8;
  localparam logic [7:0]  ADDR_CTRL        = 8'h00;
  localparam logic [7:0]  ADDR_STATUS      = 8'h04;
  localparam logic [7:0]  ADDR_MASK        = 8'h08;
  localparam logic [7:0]  ADDR_POSITION    = 8'h0C;
  localparam logic [7:0]  ADDR_COIL        = 8'h10;

  localparam int          CTRL_RES_LSB     = 0;
  localparam int          CTRL_INDEX_BIT   = 4;
  localparam int          CTRL_INTERP_BIT  = 5;
  localparam int          POSITION_STST_BIT = 16;
  localparam int          COIL_B_LSB       = 16;
  localparam int          IRQ_W            = 2;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic              interp_en;
    logic              index_en;
    logic [RES_W-1:0]  res;
  } sdms_ctrl_t;

  typedef struct packed {
    logic index_hit;
    logic standstill;
  } sdms_irq_t;

  localparam sdms_ctrl_t CTRL_RESET = '{interp_en: 1'b1, index_en: 1'b0, res: 4'h0};
  localparam sdms_irq_t  IRQ_RESET  = '{index_hit: 1'b0, standstill: 1'b0};

endpackage

// >>> verilog/sdms_sequencer.sv
// Step/direction front end: input synchroniser, sine-table sequencer,
// step interpolator, standstill detection, index output and APB registers.
// Assumes STEP and DIR from an outside controller and an APB master on MCLK.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps

// How it works
// - Only rising step edges and a change to a coarser resolution move the sequencer.
// - Step and direction pass a two-flop synchroniser.
// - 1024 table positions span one electrical revolution.
// - Direction low adds width, high subtracts.
// - Step width doubles per halving, up to 256.
// - Coarser resolution snaps to nearest grid point.
// - Full-step cycles 128, 384, 640, 896.
// - Grid points offset by half the width.
// - Coil A sine, coil B cosine of position.
// - Step edges after the first since reset or standstill start one interpolated microstep per unit of width.
// - Previous period split into equal microstep intervals.
// - No edge for 2^20 clocks means standstill.
// - Standstill starts standby only when pin selects.
// - Standstill flag set, cleared by next edge.
// - Unissued microsteps skipped when new edge arrives.
// - Index marks position zero when enabled.
// - Position wraps modulo 1024.
module sdms_sequencer
  import sdms_pkg::*;
#(
  parameter int STANDSTILL_LIMIT = STANDSTILL_CYCLES
) (
  input  wire logic              MCLK,
  input  wire logic              RESET,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic              STEP,
  input  wire logic              DIR,
  input  wire logic              POWERDOWN_SELECT_PIN,
  output logic      [CUR_W-1:0]  COIL_A_CURRENT,
  output logic      [CUR_W-1:0]  COIL_B_CURRENT,
  output logic                   INDEX,
  output logic                   STANDSTILL,
  output logic                   STANDBY_REDUCE,
  output logic                   IRQ
);

  // ---------------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------------
  function automatic logic [AMP_W-1:0] sine_point(input int p);
    int x;
    x = p * (2 * QUARTER_LEN - p);
    return AMP_W'((SINE_FULL_SCALE * 16 * x) / (5 * 4 * QUARTER_LEN * QUARTER_LEN - 4 * x));
  endfunction

  function automatic logic [POS_W-1:0] step_width(input logic [RES_W-1:0] res);
    return POS_W'(1) << res;
  endfunction

  // Grid points sit at the centre of each width-sized slice of the table,
  // so clearing the low bits and adding half the width finds the nearest one.
  function automatic logic [POS_W-1:0] snap_to_grid(input logic [POS_W-1:0] p,
                                                     input logic [RES_W-1:0] res);
    logic [POS_W-1:0] w;
    w = step_width(res);
    return (p & ~(w - POS_W'(1))) | (w >> 1);
  endfunction

  // ---------------------------------------------------------------------------
  // Quarter-wave sine table
  // ---------------------------------------------------------------------------
  logic [AMP_W-1:0] quarter_rom [0:QUARTER_LEN];

  for (genvar gi = 0; gi <= QUARTER_LEN; gi++) begin : g_rom
    assign quarter_rom[gi] = sine_point(gi);
  end

  // The full 1024-entry wave is folded onto 257 stored points by symmetry.
  function automatic logic [CUR_W-1:0] signed_sine(input logic [POS_W-1:0] p);
    logic [8:0]       idx;
    logic [AMP_W-1:0] mag;
    idx = p[8] ? (9'h100 - {1'b0, p[7:0]}) : {1'b0, p[7:0]};
    mag = quarter_rom[idx];
    return p[9] ? (CUR_W'(0) - {1'b0, mag}) : {1'b0, mag};
  endfunction

  // ---------------------------------------------------------------------------
  // Input synchroniser
  // ---------------------------------------------------------------------------
  logic step_meta;
  logic step_sync;
  logic step_prev;
  logic dir_meta;
  logic dir_sync;
  logic step_edge;

  // At the highest allowed step rate each level lasts several clocks, so
  // a plain two-flop synchroniser never misses an edge.
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      step_meta <= 1'b0;
      step_sync <= 1'b0;
      step_prev <= 1'b0;
      dir_meta  <= 1'b0;
      dir_sync  <= 1'b0;
    end else begin
      step_meta <= STEP;
      step_sync <= step_meta;
      step_prev <= step_sync;
      dir_meta  <= DIR;
      dir_sync  <= dir_meta;
    end
  end

  assign step_edge = step_sync & ~step_prev;

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  sdms_ctrl_t ctrl;
  sdms_ctrl_t next_ctrl;
  sdms_irq_t  status;
  sdms_irq_t  next_status;
  sdms_irq_t  mask;
  sdms_irq_t  next_mask;
  sdms_irq_t  events;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        wr_done;
  logic        addr_ok;

  // ---------------------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------------------
  typedef enum logic {SDMS_HOLD, SDMS_INTERP} sdms_state_t;

  sdms_state_t      state;
  sdms_state_t      next_state;
  logic [POS_W-1:0] target;
  logic [POS_W-1:0] next_target;
  logic [POS_W-1:0] pos;
  logic [POS_W-1:0] next_pos;
  logic             run_dir;
  logic             next_run_dir;
  logic [PER_W-1:0] period_cnt;
  logic [PER_W-1:0] next_period_cnt;
  logic [PER_W-1:0] tick_len;
  logic [PER_W-1:0] next_tick_len;
  logic [PER_W-1:0] tick_cnt;
  logic [PER_W-1:0] next_tick_cnt;
  logic             have_period;
  logic             next_have_period;
  logic             stst;
  logic             next_stst;
  logic [RES_W-1:0] prev_res;
  logic [POS_W-1:0] base;
  logic [POS_W-1:0] width;
  logic [PER_W-1:0] measured;

  always_comb begin
    next_state       = state;
    next_target      = target;
    next_pos         = pos;
    next_run_dir     = run_dir;
    next_period_cnt  = period_cnt;
    next_tick_len    = tick_len;
    next_tick_cnt    = tick_cnt;
    next_have_period = have_period;
    next_stst        = stst;
    events           = IRQ_RESET;
    width            = step_width(ctrl.res);
    measured         = period_cnt + PER_W'(1);
    base             = target;

    // A change to a coarser grid takes effect at once, even mid-move.
    if (ctrl.res > prev_res) begin
      base        = snap_to_grid(target, ctrl.res);
      next_target = base;
      next_pos    = base;
      next_state  = SDMS_HOLD;
    end

    // Step interval measurement and standstill detection.
    if (period_cnt != PER_W'(STANDSTILL_LIMIT - 1)) begin
      next_period_cnt = measured;
    end else if (!stst) begin
      next_stst         = 1'b1;
      next_have_period  = 1'b0;
      events.standstill = 1'b1;
    end

    if (step_edge) begin
      next_target     = dir_sync ? (base - width) : (base + width);
      next_run_dir    = dir_sync;
      next_period_cnt = '0;
      next_stst       = 1'b0;
      // The interval that just ended times the microsteps of the next one.
      // It is a true step interval only when an edge opened it. After reset
      // or standstill the first edge just starts the measurement, so that
      // edge jumps and the edge after it already interpolates.
      next_have_period = 1'b1;
      next_tick_len    = (measured >> ctrl.res) | PER_W'(1);
      next_tick_cnt    = '0;
      if (ctrl.interp_en && have_period && ctrl.res != '0) begin
        next_pos   = base;
        next_state = SDMS_INTERP;
      end else begin
        next_pos   = next_target;
        next_state = SDMS_HOLD;
      end
    end else if (state == SDMS_INTERP && ctrl.res <= prev_res) begin
      case (state)
        SDMS_INTERP: begin
          if (tick_cnt + PER_W'(1) >= tick_len) begin
            next_tick_cnt = '0;
            next_pos      = run_dir ? (pos - POS_W'(1)) : (pos + POS_W'(1));
            if (next_pos == target) begin
              next_state = SDMS_HOLD;
            end
          end else begin
            next_tick_cnt = tick_cnt + PER_W'(1);
          end
        end
        default: next_state = SDMS_HOLD;
      endcase
    end

    if (next_pos == '0 && pos != '0) begin
      events.index_hit = 1'b1;
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      state       <= SDMS_HOLD;
      target      <= '0;
      pos         <= '0;
      run_dir     <= 1'b0;
      period_cnt  <= '0;
      tick_len    <= PER_W'(1);
      tick_cnt    <= '0;
      have_period <= 1'b0;
      stst        <= 1'b0;
      prev_res    <= '0;
    end else begin
      state       <= next_state;
      target      <= next_target;
      pos         <= next_pos;
      run_dir     <= next_run_dir;
      period_cnt  <= next_period_cnt;
      tick_len    <= next_tick_len;
      tick_cnt    <= next_tick_cnt;
      have_period <= next_have_period;
      stst        <= next_stst;
      prev_res    <= ctrl.res;
    end
  end

  // ---------------------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------------------
  // One wait state: the read word is built from the address in the first
  // access cycle and shown together with PREADY in the second.
  // PSLVERR only flags unmapped words; writes to read-only words are dropped quietly.
  assign wr_done = PSEL & PENABLE & PWRITE & PREADY;
  assign addr_ok = (PADDR == ADDR_CTRL) || (PADDR == ADDR_STATUS) || (PADDR == ADDR_MASK) ||
                   (PADDR == ADDR_POSITION) || (PADDR == ADDR_COIL);

  always_comb begin
    next_ctrl    = ctrl;
    next_mask    = mask;
    next_pready  = PSEL & PENABLE & ~PREADY;
    next_pslverr = PSEL & PENABLE & ~PREADY & ~addr_ok;
    next_prdata  = PRDATA;
    // Hardware events win over a simultaneous write-one-to-clear.
    next_status  = status;
    if (wr_done && PADDR == ADDR_STATUS) begin
      next_status = status & ~sdms_irq_t'(PWDATA[IRQ_W-1:0]);
    end
    next_status = next_status | events;
    if (wr_done && PADDR == ADDR_CTRL) begin
      next_ctrl.interp_en = PWDATA[CTRL_INTERP_BIT];
      next_ctrl.index_en  = PWDATA[CTRL_INDEX_BIT];
      // Codes beyond full step are clamped so the width never exceeds 256.
      next_ctrl.res = (PWDATA[CTRL_RES_LSB +: RES_W] > RES_FULLSTEP) ? RES_FULLSTEP
                                                                     : PWDATA[CTRL_RES_LSB +: RES_W];
    end
    if (wr_done && PADDR == ADDR_MASK) begin
      next_mask = sdms_irq_t'(PWDATA[IRQ_W-1:0]);
    end
    if (PSEL && PENABLE && !PREADY) begin
      next_prdata = '0;
      case (PADDR)
        ADDR_CTRL:     next_prdata[5:0]        = ctrl;
        ADDR_STATUS:   next_prdata[IRQ_W-1:0]  = status;
        ADDR_MASK:     next_prdata[IRQ_W-1:0]  = mask;
        ADDR_POSITION: begin
          next_prdata[POS_W-1:0]          = pos;
          next_prdata[POSITION_STST_BIT]  = stst;
        end
        ADDR_COIL: begin
          next_prdata[CUR_W-1:0]              = COIL_A_CURRENT;
          next_prdata[COIL_B_LSB +: CUR_W]    = COIL_B_CURRENT;
        end
        default:       next_prdata = '0;
      endcase
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      ctrl    <= CTRL_RESET;
      status  <= IRQ_RESET;
      mask    <= IRQ_RESET;
      PRDATA  <= '0;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      ctrl    <= next_ctrl;
      status  <= next_status;
      mask    <= next_mask;
      PRDATA  <= next_prdata;
      PREADY  <= next_pready;
      PSLVERR <= next_pslverr;
    end
  end

  // ---------------------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------------------
  logic [CUR_W-1:0] next_coil_a;
  logic [CUR_W-1:0] next_coil_b;
  logic             next_index;
  logic             next_standby;
  logic             next_irq;

  always_comb begin
    next_coil_a  = signed_sine(pos);
    next_coil_b  = signed_sine(pos + POS_W'(QUARTER_LEN));
    // Offset grids never land on zero, so in coarse modes without interpolation the index stays
    // low unless a change to a finer resolution left pos off the grid; this is a limitation users must know.
    next_index   = ctrl.index_en && (pos == '0);
    next_standby = stst && POWERDOWN_SELECT_PIN;
    next_irq     = |(status & mask);
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      COIL_A_CURRENT <= '0;
      COIL_B_CURRENT <= '0;
      INDEX          <= 1'b0;
      STANDSTILL     <= 1'b0;
      STANDBY_REDUCE <= 1'b0;
      IRQ            <= 1'b0;
    end else begin
      COIL_A_CURRENT <= next_coil_a;
      COIL_B_CURRENT <= next_coil_b;
      INDEX          <= next_index;
      STANDSTILL     <= stst;
      STANDBY_REDUCE <= next_standby;
      IRQ            <= next_irq;
    end
  end

endmodule // sdms_sequencer

// >>> tb/sdms_chk.sv
// Port checker for the microstep sequencer, bound to its top module.
// Assumes STANDSTILL_LIMIT matches the design instance.
`timescale 1ns/1ps
module sdms_chk
  import sdms_pkg::*;
#(
  parameter int STANDSTILL_LIMIT = 64
) (
  input wire logic              MCLK,
  input wire logic              RESET,
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic              PREADY,
  input wire logic              PSLVERR,
  input wire logic              STEP,
  input wire logic              POWERDOWN_SELECT_PIN,
  input wire logic [CUR_W-1:0]  COIL_A_CURRENT,
  input wire logic [CUR_W-1:0]  COIL_B_CURRENT,
  input wire logic              INDEX,
  input wire logic              STANDSTILL,
  input wire logic              STANDBY_REDUCE
);
  localparam int LATE = STANDSTILL_LIMIT + 8;
  // Clocks since the last rising step input; it saturates so a long idle never wraps.
  logic [15:0] idle;
  logic [15:0] next_idle;
  logic        step_q;
  always_comb begin
    next_idle = idle;
    if (STEP && !step_q) next_idle = 16'h0000;
    else if (idle != 16'hFFFF) next_idle = idle + 16'h0001;
  end
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      idle   <= 16'h0000;
      step_q <= 1'b0;
    end else begin
      idle   <= next_idle;
      step_q <= STEP;
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  a_ready_wait: assert property (PSEL && PENABLE && !$past(PENABLE) |-> !PREADY ##1 PREADY)
    else $error("Ready did not follow exactly one wait state");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("Ready stayed high");
  a_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("Error without ready");
  a_err_range: assert property (PREADY && PADDR[1:0] == 2'b00 |-> PSLVERR == (PADDR > ADDR_COIL))
    else $error("Error flag wrong for the address");
  a_index_zero: assert property (INDEX |-> COIL_A_CURRENT == 9'h000 && COIL_B_CURRENT == 9'h0FF)
    else $error("Index away from the zero point");
  a_stst_early: assert property ($rose(STANDSTILL) |-> idle >= STANDSTILL_LIMIT)
    else $error("Standstill before the idle limit");
  a_stst_late: assert property (idle == LATE |-> STANDSTILL)
    else $error("Standstill missing after the idle limit");
  a_stst_clear: assert property (STANDSTILL && STEP && !step_q |-> ##[2:6] !STANDSTILL)
    else $error("Standstill not cleared by a step");
  a_standby_sel: assert property (STANDBY_REDUCE == (STANDSTILL && $past(POWERDOWN_SELECT_PIN)))
    else $error("Standby reduction does not follow standstill and pin");
endmodule // sdms_chk

// >>> tb/sdms_step_src.sv
// Step source standing in for the outside motion controller.
// Assumes the caller enters send just after a rising MCLK edge.
`timescale 1ns/1ps
module sdms_step_src (
  input  wire logic MCLK,
  output logic      STEP,
  output logic      DIR
);
  initial begin
    STEP = 1'b0;
    DIR  = 1'b0;
  end
  // Direction settles two clocks before the rise, high lasts per/2 clocks and low three or more, so with per
  // of 4 or more the rate never exceeds the ceiling at a 20 MHz clock.
  task automatic send(input logic d, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      @(posedge MCLK);
      DIR <= d;
      repeat (2) @(posedge MCLK);
      STEP <= 1'b1;
      repeat (per / 2) @(posedge MCLK);
      STEP <= 1'b0;
      repeat (per - per / 2 - 2) @(posedge MCLK);
    end
  endtask
endmodule // sdms_step_src

// >>> tb/sdms_sequencer_tb.sv
// Self-checking bench of the step/direction microstep sequencer.
// Assumes the step source model and the port checker bound below.
`timescale 1ns/1ps
module sdms_sequencer_tb import sdms_pkg::*;;
  localparam int LIM = 200;
  logic        mclk, rst, psel, penable, pwrite, pin, err;
  logic        pready, pslverr, step, dir, index, stst, stby, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [8:0]  coil_a, coil_b;
  logic [9:0]  e;
  int          fails, compares;
  sdms_sequencer #(.STANDSTILL_LIMIT(LIM)) DUT (
    .MCLK(mclk), .RESET(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .STEP(step), .DIR(dir),
    .POWERDOWN_SELECT_PIN(pin), .COIL_A_CURRENT(coil_a), .COIL_B_CURRENT(coil_b), .INDEX(index),
    .STANDSTILL(stst), .STANDBY_REDUCE(stby), .IRQ(irq)
  );
  sdms_step_src src (.MCLK(mclk), .STEP(step), .DIR(dir));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic give_verdict;
    $display("Counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request holds until ready is sampled high at an edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fails++;
      give_verdict();
    end
  endtask
  task automatic pos(input logic [9:0] x);
    apb(1'b0, ADDR_POSITION, 32'h0);
    check({22'h0, q[9:0]}, {22'h0, x});
  endtask
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pin = 1'b1;
    rst = 1'b1;
    fails = 0;
    compares = 0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(q, 32'h0000_0020);
    apb(1'b0, ADDR_MASK, 32'h0);
    check(q, 32'h0);
    apb(1'b0, ADDR_COIL, 32'h0);
    check(q, 32'h00FF_0000);
    apb(1'b0, 8'h14, 32'h0);
    check({31'h0, err}, 32'h1);
    check(q, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h0000_0010);
    src.send(1'b0, 3, 10);
    pos(10'h003);
    src.send(1'b1, 4, 10);
    pos(10'h3FF);
    src.send(1'b0, 1, 10);
    pos(10'h000);
    check({31'h0, index}, 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(q & 32'h2, 32'h2);
    apb(1'b1, ADDR_MASK, 32'h2);
    repeat (2) @(posedge mclk);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, ADDR_STATUS, 32'h2);
    repeat (2) @(posedge mclk);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, ADDR_MASK, 32'h0);
    src.send(1'b0, 5, 10);
    pos(10'h005);
    apb(1'b1, ADDR_CTRL, 32'h0000_0017);
    pos(10'h040);
    src.send(1'b0, 1, 10);
    pos(10'h0C0);
    apb(1'b1, ADDR_CTRL, 32'h0000_0018);
    pos(10'h080);
    apb(1'b0, ADDR_COIL, 32'h0);
    check({23'h0, q[24:16]}, {23'h0, q[8:0]});
    check(q, 32'h00B4_00B4);
    e = 10'h080;
    for (int k = 0; k < 4; k++) begin
      e = e + 10'h100;
      src.send(1'b0, 1, 10);
      pos(e);
    end
    src.send(1'b1, 1, 10);
    pos(10'h380);
    apb(1'b0, ADDR_COIL, 32'h0);
    check(q, 32'h00B4_014C);
    repeat (LIM + 20) @(posedge mclk);
    check({31'h0, stst}, 32'h1);
    check({31'h0, stby}, 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(q & 32'h1, 32'h1);
    pin <= 1'b0;
    repeat (3) @(posedge mclk);
    check({31'h0, stby}, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h0000_0024);
    src.send(1'b0, 1, 80);
    pos(10'h390);
    check({31'h0, stst}, 32'h0);
    src.send(1'b0, 1, 8);
    apb(1'b0, ADDR_POSITION, 32'h0);
    check({31'h0, q[9:0] > 10'h390 && q[9:0] < 10'h3A0}, 32'h1);
    repeat (120) @(posedge mclk);
    pos(10'h3A0);
    give_verdict();
  end
endmodule // sdms_sequencer_tb

bind sdms_sequencer sdms_chk #(.STANDSTILL_LIMIT(STANDSTILL_LIMIT)) u_chk (
  .MCLK(MCLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .STEP(STEP), .POWERDOWN_SELECT_PIN(POWERDOWN_SELECT_PIN),
  .COIL_A_CURRENT(COIL_A_CURRENT), .COIL_B_CURRENT(COIL_B_CURRENT), .INDEX(INDEX),
  .STANDSTILL(STANDSTILL), .STANDBY_REDUCE(STANDBY_REDUCE)
);
